// file: design/bsms_pkg.sv
/*
 Shared constants and types of the boot strap mode selector.
 Assumes a 10 MHz device clock and a 32-bit APB register port.
*/
package bsms_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int BREAK_MIN_US = 1000;
  localparam int BREAK_MIN_CYC = BREAK_MIN_US * CLK_MHZ;
  localparam int BREAK_WIN_US = 20000;
  localparam int BREAK_WIN_CYC = BREAK_WIN_US * CLK_MHZ;
  localparam int RESTORE_NOM_S = 8;
  localparam int RESTORE_NOM_CYC = RESTORE_NOM_S * CLK_MHZ * 1000000;

  // ---------------------------------------------------------------
  // Strap codes, bit 2 first
  // ---------------------------------------------------------------
  localparam logic [2:0] STRAP_LOAD = 3'h4;
  localparam logic [2:0] STRAP_RUN2 = 3'h1;
  localparam logic [2:0] STRAP_RUN4 = 3'h0;
  localparam logic [2:0] STRAP_BREAK = 3'h2;
  localparam logic [2:0] STRAP_RESTORE = 3'h3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CMD = 12'h008;
  localparam int CTRL_RF_LSB = 0;
  localparam int CTRL_P2_OE = 2;
  localparam int CTRL_P2_VAL = 3;
  localparam int CTRL_SET_LSB = 4;
  localparam int CMD_START = 0;
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_LOAD = 8;
  localparam int ST_BRK = 9;
  localparam int ST_BUSY = 10;
  localparam int ST_OVERDUE = 11;
  localparam int ST_PEND = 12;
  localparam logic [1:0] CTRL_RF_RST = 2'h0;
  localparam logic [7:0] FACTORY_SECTOR = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RESTORE_NONE,
    RESTORE_PARAMS,
    RESTORE_IMAGE_PARAMS
  } bsms_restore_t;

  typedef enum logic [2:0] {
    BOOT_RUN_FOUR,
    BOOT_RUN_TWO,
    BOOT_LOAD,
    BOOT_BREAK,
    BOOT_RESTORE,
    BOOT_RESERVED
  } bsms_boot_t;

  typedef struct packed {
    logic swd_two_wire;
    logic jtag_four_wire;
    logic uart0_loader;
  } bsms_route_t;

endpackage

// file: design/bsms_cycle_timer.sv
/*
 Saturating cycle counter: hit is high once run has stayed high
 for LIMIT cycles. Assumes run comes from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bsms_cycle_timer #(
  parameter int W = 8,
  parameter logic [W-1:0] LIMIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic hit
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign hit = run && (cnt_reg == LIMIT);

endmodule
`default_nettype wire

// file: design/bsms_top.sv
/*
 Boot strap mode selector: latches the strap pins before the core
 leaves reset, picks the boot flow and debug routing, runs the
 fail-safe factory restore and guards the factory flash sector.
 Assumes an APB master on clk, a flash engine that performs the
 restore, and a non-volatile flag that survives power loss.
*/
// The APB slave port and the register offsets were decided locally.
// What this block does
// - The strap pins are sampled and latched before core reset ends.
// - The latched code picks the boot flow and debug/UART routing.
// - Code 100 enters serial load, waits forever, with 4-wire JTAG.
// - Code 001 boots functionally with two-wire SWD.
// - Code 000 boots functionally with four-wire JTAG.
// - Code 010 checks UART receive for a break: load if seen, else run.
// - Code 011 starts the factory restore when reset is toggled.
// - Restore settings are none, parameters, or image plus parameters.
// - A restore cut off by power loss resumes at the next power-up.
// - The factory sector is never granted to host accesses.
// - A restore is expected to take about eight seconds.
// - Strap pin 2 may be reused after boot, as an output only.
// - Strap pins 0 and 1 drive the RF switch after boot.
`timescale 1ns/1ps
`default_nettype none
module bsms_top
  import bsms_pkg::*;
#(
  parameter int BREAK_WIN = BREAK_WIN_CYC,
  parameter int RESTORE_CYC = RESTORE_NOM_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] boot_strap_pins_in,
  output logic [2:0] boot_strap_pins_out,
  output logic [2:0] boot_strap_pins_oe,
  input wire logic reset_pin_low_active,
  input wire logic uart_rx_in,
  input wire logic restore_pend_nv_in,
  output logic restore_pend_nv_out,
  output logic restore_req,
  output bsms_restore_t restore_kind,
  input wire logic restore_done,
  input wire logic host_fl_req,
  input wire logic [7:0] host_fl_sector,
  output logic host_fl_grant,
  output logic host_fl_denied,
  output logic core_rst,
  output bsms_boot_t boot_mode,
  output bsms_route_t route,
  output logic serial_load
);

  // ---------------------------------------------------------------
  // Types and decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_BREAK,
    ST_RESTORE,
    ST_LOAD,
    ST_RUN
  } bsms_state_t;

  function automatic bsms_boot_t decode(input logic [2:0] code);
    case (code)
      STRAP_LOAD: decode = BOOT_LOAD;
      STRAP_RUN2: decode = BOOT_RUN_TWO;
      STRAP_RUN4: decode = BOOT_RUN_FOUR;
      STRAP_BREAK: decode = BOOT_BREAK;
      STRAP_RESTORE: decode = BOOT_RESTORE;
      default: decode = BOOT_RESERVED;
    endcase
  endfunction

  function automatic bsms_route_t route_of(input bsms_boot_t m,
                                           input logic ld);
    route_of = '{swd_two_wire: (m == BOOT_RUN_TWO),
                 jtag_four_wire: (m != BOOT_RUN_TWO),
                 uart0_loader: ld};
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [2:0] strap_s2;
  logic rst_pin_s2;
  logic rx_s2;
  logic nv_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      pin_s1 <= {restore_pend_nv_in, uart_rx_in, reset_pin_low_active,
                 boot_strap_pins_in};
      pin_s2 <= pin_s1;
    end
  end

  assign strap_s2 = pin_s2[2:0];
  assign rst_pin_s2 = pin_s2[3];
  assign rx_s2 = pin_s2[4];
  assign nv_s2 = pin_s2[5];

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  bsms_state_t state_reg;
  bsms_state_t state_next;
  logic [2:0] strap_reg;
  logic [1:0] rf_reg;
  logic p2_oe_reg;
  logic p2_val_reg;
  bsms_restore_t setting_reg;
  logic sw_start_reg;
  logic brk_seen_reg;
  logic overdue_reg;
  logic brk_hit;
  logic win_hit;
  logic dur_hit;
  logic release_now;
  logic hw_restore;
  bsms_boot_t mode_now;

  assign release_now = (state_reg == ST_SAMPLE) && rst_pin_s2;
  assign mode_now = decode(strap_s2);
  assign hw_restore = (mode_now == BOOT_RESTORE) &&
                      (setting_reg != RESTORE_NONE);

  bsms_cycle_timer #(.W(16), .LIMIT(16'(BREAK_MIN_CYC))) u_brk (
    .clk(clk),
    .rst(rst),
    .run((state_reg == ST_BREAK) && !rx_s2),
    .hit(brk_hit)
  );

  bsms_cycle_timer #(.W(24), .LIMIT(24'(BREAK_WIN))) u_win (
    .clk(clk),
    .rst(rst),
    .run(state_reg == ST_BREAK),
    .hit(win_hit)
  );

  bsms_cycle_timer #(.W(28), .LIMIT(28'(RESTORE_CYC))) u_dur (
    .clk(clk),
    .rst(rst),
    .run(state_reg == ST_RESTORE),
    .hit(dur_hit)
  );

  // ---------------------------------------------------------------
  // Boot flow
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SAMPLE: begin
        if (rst_pin_s2) begin
          if (nv_s2 || hw_restore) begin
            state_next = ST_RESTORE;
          end else if (mode_now == BOOT_LOAD) begin
            state_next = ST_LOAD;
          end else if (mode_now == BOOT_BREAK) begin
            state_next = ST_BREAK;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_BREAK: begin
        if (brk_hit) begin
          state_next = ST_LOAD;
        end else if (win_hit) begin
          state_next = ST_RUN;
        end
      end
      ST_RESTORE: begin
        if (restore_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sw_start_reg && setting_reg != RESTORE_NONE) begin
          state_next = ST_RESTORE;
        end
      end
      ST_LOAD: state_next = ST_LOAD;
      default: state_next = ST_SAMPLE;
    endcase
    if (!rst_pin_s2) begin
      state_next = ST_SAMPLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_SAMPLE;
      core_rst <= 1'b1;
      serial_load <= 1'b0;
    end else begin
      state_reg <= state_next;
      core_rst <= (state_next == ST_SAMPLE);
      serial_load <= (state_next == ST_LOAD);
    end
  end

  // Strap code caught on the release edge, then routing follows it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_reg <= 3'h0;
      boot_mode <= BOOT_RUN_FOUR;
      route <= '{swd_two_wire: 1'b0, jtag_four_wire: 1'b1,
                 uart0_loader: 1'b0};
    end else if (release_now) begin
      strap_reg <= strap_s2;
      boot_mode <= mode_now;
      route <= route_of(mode_now, (mode_now == BOOT_LOAD) ||
                                  (mode_now == BOOT_BREAK));
    end else if (state_reg == ST_BREAK && win_hit && !brk_hit) begin
      route <= route_of(boot_mode, 1'b0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brk_seen_reg <= 1'b0;
    end else if (release_now) begin
      brk_seen_reg <= 1'b0;
    end else if (state_reg == ST_BREAK && brk_hit) begin
      brk_seen_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Factory restore
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restore_req <= 1'b0;
      restore_kind <= RESTORE_NONE;
      restore_pend_nv_out <= 1'b0;
    end else begin
      restore_req <= (state_reg == ST_RESTORE) && !restore_done;
      restore_kind <= (state_reg == ST_RESTORE) ? setting_reg
                                                : RESTORE_NONE;
      if (state_reg == ST_RESTORE && restore_done) begin
        restore_pend_nv_out <= 1'b0;
      end else if (state_reg == ST_RESTORE) begin
        restore_pend_nv_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overdue_reg <= 1'b0;
    end else if (state_reg != ST_RESTORE && state_next == ST_RESTORE) begin
      overdue_reg <= 1'b0;
    end else if (dur_hit) begin
      overdue_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Host flash guard and strap pin reuse
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_fl_grant <= 1'b0;
      host_fl_denied <= 1'b0;
    end else begin
      host_fl_grant <= host_fl_req &&
                       (host_fl_sector != FACTORY_SECTOR);
      host_fl_denied <= host_fl_req &&
                        (host_fl_sector == FACTORY_SECTOR);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_strap_pins_oe <= 3'h0;
      boot_strap_pins_out <= 3'h0;
    end else if (state_reg == ST_SAMPLE) begin
      boot_strap_pins_oe <= 3'h0;
      boot_strap_pins_out <= 3'h0;
    end else begin
      boot_strap_pins_oe <= {p2_oe_reg, 2'h3};
      boot_strap_pins_out <= {p2_val_reg, rf_reg};
    end
  end

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  logic setup_ph;
  logic wr_ok;
  logic mapped;

  assign setup_ph = psel && !penable;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_CMD);
  assign wr_ok = psel && penable && pready && pwrite && !pslverr &&
                 pstrb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        pslverr <= !mapped;
        prdata <= 32'h0000_0000;
        if (!pwrite && paddr == OFS_CTRL) begin
          prdata[CTRL_RF_LSB +: 2] <= rf_reg;
          prdata[CTRL_P2_OE] <= p2_oe_reg;
          prdata[CTRL_P2_VAL] <= p2_val_reg;
          prdata[CTRL_SET_LSB +: 2] <= setting_reg;
        end else if (!pwrite && paddr == OFS_STATUS) begin
          prdata[ST_STRAP_LSB +: 3] <= strap_reg;
          prdata[ST_MODE_LSB +: 3] <= boot_mode;
          prdata[bsms_pkg::ST_LOAD] <= serial_load;
          prdata[ST_BRK] <= brk_seen_reg;
          prdata[ST_BUSY] <= (state_reg == ST_RESTORE);
          prdata[ST_OVERDUE] <= overdue_reg;
          prdata[ST_PEND] <= restore_pend_nv_out;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rf_reg <= CTRL_RF_RST;
      p2_oe_reg <= 1'b0;
      p2_val_reg <= 1'b0;
      setting_reg <= RESTORE_IMAGE_PARAMS;
    end else if (wr_ok && paddr == OFS_CTRL) begin
      rf_reg <= pwdata[CTRL_RF_LSB +: 2];
      p2_oe_reg <= pwdata[CTRL_P2_OE];
      p2_val_reg <= pwdata[CTRL_P2_VAL];
      if (pwdata[CTRL_SET_LSB +: 2] != 2'h3) begin
        setting_reg <= bsms_restore_t'(pwdata[CTRL_SET_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_start_reg <= 1'b0;
    end else begin
      sw_start_reg <= wr_ok && (paddr == OFS_CMD) && pwdata[CMD_START];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_release;
    state_reg == ST_SAMPLE && rst_pin_s2;
  endsequence

  sequence s_restore_go;
    s_release ##0 (hw_restore && !nv_s2);
  endsequence

  AST_LATCH: assert property (s_release |=> strap_reg == $past(strap_s2)
      && !core_rst) else $error("strap not latched at release");
  AST_MODE: assert property (s_release |=> boot_mode == decode(strap_reg))
    else $error("boot mode differs from strap code");
  AST_LOAD: assert property (state_reg == ST_LOAD && rst_pin_s2 |=>
      state_reg == ST_LOAD && serial_load && route.jtag_four_wire)
    else $error("serial load left or wrong routing");
  AST_TWO: assert property (!core_rst && boot_mode == BOOT_RUN_TWO |->
      route.swd_two_wire && !route.jtag_four_wire)
    else $error("two-wire debug not routed");
  AST_FOUR: assert property (!core_rst && boot_mode == BOOT_RUN_FOUR |->
      route.jtag_four_wire && !route.swd_two_wire)
    else $error("four-wire debug not routed");
  AST_BREAK: assert property (state_reg == ST_BREAK && brk_hit &&
      rst_pin_s2 |=> state_reg == ST_LOAD && brk_seen_reg)
    else $error("break not followed by serial load");
  AST_RESTORE: assert property (s_restore_go |=> state_reg == ST_RESTORE
      ##1 restore_req && restore_pend_nv_out)
    else $error("restore not started");
  AST_RESUME: assert property (s_release ##0 nv_s2 |=>
      state_reg == ST_RESTORE) else $error("restore not resumed");
  AST_SECTOR: assert property (host_fl_req &&
      host_fl_sector == FACTORY_SECTOR |=> !host_fl_grant && host_fl_denied)
    else $error("factory sector granted");
  AST_PINS: assert property (state_reg == ST_SAMPLE [*2] |->
      boot_strap_pins_oe == 3'h0) else $error("strap pin driven");
  AST_RF: assert property (state_reg == ST_RUN && $past(state_reg) ==
      ST_RUN |-> boot_strap_pins_oe[1:0] == 2'h3 &&
      boot_strap_pins_out[1:0] == $past(rf_reg))
    else $error("RF switch pins not driven");
  AST_RSVD: assert property (s_release ##0 !nv_s2 ##0
      mode_now == BOOT_RESERVED |=> state_reg == ST_RUN &&
      route.jtag_four_wire) else $error("reserved code mishandled");

endmodule
`default_nettype wire

// file: bench/bsms_far_side.sv
/*
 Far side of the boot strap mode selector: strap resistors on the
 shared strap pins and the flash engine that carries out a restore.
 Assumes the bench sets the resistor levels and the engine delay.
*/
`timescale 1ns/1ps
`default_nettype none
module bsms_far_side (
  input wire logic clk,
  input wire logic [2:0] strap_level,
  input wire logic [2:0] pins_out,
  input wire logic [2:0] pins_oe,
  input wire logic restore_req,
  input wire logic [7:0] done_delay,
  output logic [2:0] pins_wire,
  output logic restore_done
);
  // ---------------------------------------------------------------
  // Strap pins: block drive wins over the pull resistors
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pins_wire[i] = pins_oe[i] ? pins_out[i] : strap_level[i];
    end
  end

  // ---------------------------------------------------------------
  // Flash engine: done held until the request drops
  // ---------------------------------------------------------------
  int cnt = 0;
  always @(posedge clk) begin
    if (!restore_req) begin
      cnt <= 0;
      restore_done <= 1'b0;
    end else if (cnt == int'(done_delay)) begin
      restore_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_boot_strap_mode_select.sv
/*
 Self-checking bench of the boot strap mode selector.
 Assumes the design package and the far side model are compiled
 first; APB master, reset pin, UART line and host port live here.
*/
`timescale 1ns/1ps
`default_nettype none
module test_boot_strap_mode_select;
  import bsms_pkg::*;
  localparam int BW = 12000;
  localparam int RC = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] strap = 3'h0;
  logic [2:0] pins_w;
  logic [2:0] pins_out;
  logic [2:0] pins_oe;
  logic rpin = 1'b0;
  logic rx = 1'b1;
  logic nv_in = 1'b0;
  logic nv_out;
  logic rreq;
  bsms_restore_t rkind;
  logic rdone;
  logic hreq = 1'b0;
  logic [7:0] hsec = 8'h00;
  logic hgrant;
  logic hden;
  logic core_rst;
  bsms_boot_t boot_mode;
  bsms_route_t route;
  logic serial_load;
  logic [7:0] dly = 8'h00;
  logic [31:0] rd;
  logic er;
  logic [31:0] seed = 32'd66233;
  int checks = 0;
  int n_mismatch = 0;

  bsms_top #(.BREAK_WIN(BW), .RESTORE_CYC(RC)) bsms_top_inst (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_strap_pins_in(pins_w),
    .boot_strap_pins_out(pins_out), .boot_strap_pins_oe(pins_oe),
    .reset_pin_low_active(rpin), .uart_rx_in(rx),
    .restore_pend_nv_in(nv_in), .restore_pend_nv_out(nv_out),
    .restore_req(rreq), .restore_kind(rkind), .restore_done(rdone),
    .host_fl_req(hreq), .host_fl_sector(hsec),
    .host_fl_grant(hgrant), .host_fl_denied(hden),
    .core_rst(core_rst), .boot_mode(boot_mode), .route(route),
    .serial_load(serial_load)
  );

  bsms_far_side bsms_far_side_inst (
    .clk(clk), .strap_level(strap), .pins_out(pins_out),
    .pins_oe(pins_oe), .restore_req(rreq), .done_delay(dly),
    .pins_wire(pins_w), .restore_done(rdone)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function logic [31:0] rand_next();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction

  function automatic bsms_boot_t exp_mode(input logic [2:0] c);
    case (c)
      STRAP_RUN4: return BOOT_RUN_FOUR;
      STRAP_RUN2: return BOOT_RUN_TWO;
      STRAP_LOAD: return BOOT_LOAD;
      STRAP_BREAK: return BOOT_BREAK;
      STRAP_RESTORE: return BOOT_RESTORE;
      default: return BOOT_RESERVED;
    endcase
  endfunction

  function automatic bsms_route_t exp_route(input logic [2:0] c);
    case (c)
      STRAP_RUN2: return bsms_route_t'(3'b100);
      STRAP_LOAD: return bsms_route_t'(3'b011);
      default: return bsms_route_t'(3'b010);
    endcase
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task boot(input logic [2:0] c);
    strap <= c;
    rpin <= 1'b0;
    repeat (4) @(posedge clk);
    rpin <= 1'b1;
    do begin
      @(posedge clk);
    end while (core_rst !== 1'b0);
    @(posedge clk);
  endtask

  task wait_idle();
    int n;
    n = 0;
    while (rreq !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    logic [1:0] rf;
    logic [1:0] hx;
    int n;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h20);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      if (c == 3) continue;
      rf = 2'(rand_next());
      apb(1'b1, OFS_CTRL, {26'h0, 2'h2, 1'b1, 1'b1, rf});
      boot(3'(c));
      chk(32'(boot_mode), 32'(exp_mode(3'(c))));
      chk(32'(core_rst), 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[2:0]), 32'(c));
      if (c == 2) repeat (BW + 5) @(posedge clk);
      chk(32'(route), 32'(exp_route(3'(c))));
      chk(32'(serial_load), 32'(c == 4));
      chk(32'(pins_oe), 32'h7);
      chk(32'(pins_out), 32'({1'b1, rf}));
      $display("test boot code %0d done", c);
    end
    boot(STRAP_LOAD);
    repeat (300) @(posedge clk);
    chk(32'(serial_load), 32'h1);
    boot(STRAP_RUN4);
    chk(32'(serial_load), 32'h0);
    $display("test serial load exit done");
    rx <= 1'b0;
    boot(STRAP_BREAK);
    n = 0;
    while (serial_load !== 1'b1 && n < BREAK_MIN_CYC + 200) begin
      @(posedge clk);
      n++;
    end
    rx <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[ST_BRK]), 32'h1);
    chk(32'(rd[ST_LOAD]), 32'h1);
    chk(32'(serial_load), 32'h1);
    $display("test break seen done");
    for (int k = 0; k < 4; k++) begin
      dly <= (k == 3) ? 8'd150 : 8'(rand_next() % 50);
      apb(1'b1, OFS_CTRL, {26'h0, 2'(k == 3 ? 2 : k), 4'h3});
      boot(STRAP_RESTORE);
      chk(32'(rreq), 32'(k != 0));
      if (k != 0) begin
        chk(32'(rkind), 32'(k == 3 ? 2 : k));
        chk(32'(nv_out), 32'h1);
        wait_idle();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[ST_OVERDUE]), 32'(k == 3));
        chk(32'(nv_out), 32'h0);
      end
      $display("test restore setting %0d done", k);
    end
    nv_in <= 1'b1;
    dly <= 8'd5;
    boot(STRAP_RUN4);
    chk(32'(rreq), 32'h1);
    nv_in <= 1'b0;
    wait_idle();
    $display("test restore resume done");
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(rreq), 32'h1);
    chk(32'(rkind), 32'(RESTORE_IMAGE_PARAMS));
    wait_idle();
    $display("test software restore done");
    for (int i = 0; i < 16; i++) begin
      hsec <= (i == 0) ? FACTORY_SECTOR : 8'(rand_next());
      hreq <= 1'b1;
      @(posedge clk);
      hreq <= 1'b0;
      @(posedge clk);
      hx = (hsec == FACTORY_SECTOR) ? 2'b01 : 2'b10;
      chk(32'({hgrant, hden}), 32'(hx));
    end
    $display("test host flash done");
    print_verdict();
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
